/* design/sbr_top.sv */
/*
  Subbank register access block: direct pointer registers and data
  windows for three serial ports and the DMA controller, plus the
  directly mapped DMA priority and enable control register.
  Assumes the core issues at most one read or write per cycle on the
  data-memory bus, on the same clock; read data follows one cycle later.
  Peripheral cores see each accepted window write as a one-cycle strobe.
*/
`include "sbr_consts.svh"

module sbr_top
  import sbr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic [2:0] o_sp_wr,
  output logic [15:0] o_sp_wr_sub,
  output logic [15:0] o_sp_wr_data,
  output logic o_dma_wr,
  output logic [15:0] o_dma_wr_sub,
  output logic [15:0] o_dma_wr_data,
  output logic [15:0] o_dma_prio_enable
);

  sbr_target_e tgt;
  logic acc;
  logic [2:0] sp_ptr_wr;
  logic [2:0] sp_win_wr;
  logic [2:0] sp_hit;
  sbr_word_t sp_ptr [`SBR_NUM_SP];
  sbr_word_t sp_rdata [`SBR_NUM_SP];
  sbr_word_t sp_sub_sel;
  sbr_word_t dma_ptr_r;
  sbr_word_t dma_prec_r;
  sbr_word_t dma_bank_r [`SBR_DMA_DEPTH];
  logic dma_hit;
  logic dma_win_acc;
  logic dma_win_wr;
  sbr_word_t rdata_nxt;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic [2:0] sp_wr_r;
  logic [15:0] sp_wr_sub_r;
  logic [15:0] sp_wr_data_r;
  logic dma_wr_r;
  logic [15:0] dma_wr_sub_r;
  logic [15:0] dma_wr_data_r;

  // map a data-memory address onto its target
  function automatic sbr_target_e decode(input logic [15:0] addr);
    case (addr)
      `SBR_ADDR_SP0_PTR: decode = SBR_T_SP0_PTR;
      `SBR_ADDR_SP0_WIN: decode = SBR_T_SP0_WIN;
      `SBR_ADDR_SP1_PTR: decode = SBR_T_SP1_PTR;
      `SBR_ADDR_SP1_WIN: decode = SBR_T_SP1_WIN;
      `SBR_ADDR_SP2_PTR: decode = SBR_T_SP2_PTR;
      `SBR_ADDR_SP2_WIN: decode = SBR_T_SP2_WIN;
      `SBR_ADDR_DMA_PREC: decode = SBR_T_DMA_PREC;
      `SBR_ADDR_DMA_PTR: decode = SBR_T_DMA_PTR;
      `SBR_ADDR_DMA_AUTO: decode = SBR_T_DMA_AUTO;
      `SBR_ADDR_DMA_PLAIN: decode = SBR_T_DMA_PLAIN;
      default: decode = SBR_T_NONE;
    endcase
  endfunction

  // dma subaddress holds a register: 00h-3Eh less the two reserved slots
  function automatic logic dma_sub_valid(input sbr_word_t sub);
    dma_sub_valid = (sub <= `SBR_DMA_SUB_CECTL) &&
                    (sub != `SBR_DMA_SUB_RSV_A) && (sub != `SBR_DMA_SUB_RSV_B);
  endfunction

  // address decode and per-port strobes
  assign tgt = decode(i_addr);
  assign acc = i_rd | i_wr;
  assign sp_ptr_wr = {3{i_wr}} & {tgt == SBR_T_SP2_PTR, tgt == SBR_T_SP1_PTR,
                                  tgt == SBR_T_SP0_PTR};
  assign sp_win_wr = {3{i_wr}} & {tgt == SBR_T_SP2_WIN, tgt == SBR_T_SP1_WIN,
                                  tgt == SBR_T_SP0_WIN};

  // one subbank per serial port
  for (genvar g = 0; g < `SBR_NUM_SP; g++) begin : g_sp
    sbr_serial_bank u_bank (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_ptr_wr(sp_ptr_wr[g]),
      .i_win_wr(sp_win_wr[g]),
      .i_wdata(i_wdata),
      .o_ptr(sp_ptr[g]),
      .o_win_rdata(sp_rdata[g]),
      .o_win_hit(sp_hit[g])
    );
  end

  // pointer of the serial port whose window is being written
  always_comb begin
    sp_sub_sel = `SBR_RST_WORD;
    for (int k = 0; k < `SBR_NUM_SP; k++) begin
      if (sp_win_wr[k]) begin
        sp_sub_sel = sp_ptr[k];
      end
    end
  end

  // dma window qualifiers
  assign dma_win_acc = (tgt == SBR_T_DMA_AUTO) || (tgt == SBR_T_DMA_PLAIN);
  assign dma_win_wr = i_wr && dma_win_acc;
  assign dma_hit = dma_sub_valid(dma_ptr_r);

  // directly mapped priority and enable control
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      dma_prec_r <= `SBR_RST_WORD;
    end else if (i_wr && tgt == SBR_T_DMA_PREC) begin
      dma_prec_r <= i_wdata;
    end
  end

  // dma pointer: direct write, or post-increment on the auto window only
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      dma_ptr_r <= `SBR_RST_WORD;
    end else if (i_wr && tgt == SBR_T_DMA_PTR) begin
      dma_ptr_r <= i_wdata;
    end else if (acc && tgt == SBR_T_DMA_AUTO) begin
      dma_ptr_r <= dma_ptr_r + `SBR_PTR_STEP;
    end
  end

  // dma subbank storage; the plain window never touches the pointer
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < `SBR_DMA_DEPTH; k++) begin
        dma_bank_r[k] <= `SBR_RST_WORD;
      end
    end else if (dma_win_wr && dma_hit) begin
      dma_bank_r[dma_ptr_r[5:0]] <= i_wdata;
    end
  end

  // read data selection, taken before any pointer advance
  always_comb begin
    rdata_nxt = `SBR_RST_WORD;
    case (tgt)
      SBR_T_SP0_PTR: rdata_nxt = sp_ptr[0];
      SBR_T_SP0_WIN: rdata_nxt = sp_rdata[0];
      SBR_T_SP1_PTR: rdata_nxt = sp_ptr[1];
      SBR_T_SP1_WIN: rdata_nxt = sp_rdata[1];
      SBR_T_SP2_PTR: rdata_nxt = sp_ptr[2];
      SBR_T_SP2_WIN: rdata_nxt = sp_rdata[2];
      SBR_T_DMA_PREC: rdata_nxt = dma_prec_r;
      SBR_T_DMA_PTR: rdata_nxt = dma_ptr_r;
      SBR_T_DMA_AUTO,
      SBR_T_DMA_PLAIN: rdata_nxt = dma_hit ? dma_bank_r[dma_ptr_r[5:0]] : `SBR_RST_WORD;
      default: rdata_nxt = `SBR_RST_WORD;
    endcase
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= `SBR_RST_WORD;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= i_rd;
      if (i_rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // serial write notification to the port cores, holes excluded
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sp_wr_r <= 3'h0;
      sp_wr_sub_r <= `SBR_RST_WORD;
      sp_wr_data_r <= `SBR_RST_WORD;
    end else begin
      sp_wr_r <= sp_win_wr & sp_hit;
      if (|(sp_win_wr & sp_hit)) begin
        sp_wr_sub_r <= sp_sub_sel;
        sp_wr_data_r <= i_wdata;
      end
    end
  end

  // dma write notification to the controller core
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      dma_wr_r <= 1'b0;
      dma_wr_sub_r <= `SBR_RST_WORD;
      dma_wr_data_r <= `SBR_RST_WORD;
    end else begin
      dma_wr_r <= dma_win_wr && dma_hit;
      if (dma_win_wr && dma_hit) begin
        dma_wr_sub_r <= dma_ptr_r;
        dma_wr_data_r <= i_wdata;
      end
    end
  end

  // outputs straight from flip-flops
  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_sp_wr = sp_wr_r;
  assign o_sp_wr_sub = sp_wr_sub_r;
  assign o_sp_wr_data = sp_wr_data_r;
  assign o_dma_wr = dma_wr_r;
  assign o_dma_wr_sub = dma_wr_sub_r;
  assign o_dma_wr_data = dma_wr_data_r;
  assign o_dma_prio_enable = dma_prec_r;

endmodule

/* design/sbr_consts.svh */
/*
  Constants for the subbank register access block: direct data-memory
  locations, subaddress limits, reset values and storage depths.
  Assumes a 16-bit data-memory address and 16-bit data words.
*/
`ifndef SBR_CONSTS_SVH
`define SBR_CONSTS_SVH

// direct data-memory locations
`define SBR_ADDR_SP2_PTR 16'h0034
`define SBR_ADDR_SP2_WIN 16'h0035
`define SBR_ADDR_SP0_PTR 16'h0038
`define SBR_ADDR_SP0_WIN 16'h0039
`define SBR_ADDR_SP1_PTR 16'h0048
`define SBR_ADDR_SP1_WIN 16'h0049
`define SBR_ADDR_DMA_PREC 16'h0054
`define SBR_ADDR_DMA_PTR 16'h0055
`define SBR_ADDR_DMA_AUTO 16'h0056
`define SBR_ADDR_DMA_PLAIN 16'h0057

// serial port subaddress map
`define SBR_SP_SUB_PIN_CTRL 16'h000E
`define SBR_SP_SUB_EXT_FIRST 16'h0010
`define SBR_SP_SUB_EXT_LAST 16'h001B
`define SBR_SP_DEPTH 32

// dma subaddress map
`define SBR_DMA_SUB_RSV_A 16'h0028
`define SBR_DMA_SUB_RSV_B 16'h0029
`define SBR_DMA_SUB_CECTL 16'h003E
`define SBR_DMA_DEPTH 64
`define SBR_PTR_STEP 16'h0001

// reset value and serial port count
`define SBR_RST_WORD 16'h0000
`define SBR_NUM_SP 3

`endif

/* design/sbr_pkg.sv */
/*
  Types shared by the subbank register access block.
  Assumes sbr_consts.svh supplies the numeric constants.
*/
package sbr_pkg;
  typedef logic [15:0] sbr_word_t;

  // target selected by a data-memory address
  typedef enum logic [3:0] {
    SBR_T_NONE,
    SBR_T_SP0_PTR,
    SBR_T_SP0_WIN,
    SBR_T_SP1_PTR,
    SBR_T_SP1_WIN,
    SBR_T_SP2_PTR,
    SBR_T_SP2_WIN,
    SBR_T_DMA_PREC,
    SBR_T_DMA_PTR,
    SBR_T_DMA_AUTO,
    SBR_T_DMA_PLAIN
  } sbr_target_e;
endpackage

/* design/sbr_serial_bank.sv */
/*
  One serial port subbank: a pointer register and the control registers
  it selects through the data window.
  Assumes single-cycle write strobes from the parent on the same clock.
*/
`include "sbr_consts.svh"

module sbr_serial_bank
  import sbr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ptr_wr,
  input wire logic i_win_wr,
  input wire sbr_word_t i_wdata,
  output sbr_word_t o_ptr,
  output sbr_word_t o_win_rdata,
  output logic o_win_hit
);

  sbr_word_t ptr_r;
  sbr_word_t bank_r [`SBR_SP_DEPTH];

  // subaddress holds a register: basic set or 128-channel extras
  function automatic logic sp_sub_valid(input sbr_word_t sub);
    sp_sub_valid = (sub <= `SBR_SP_SUB_PIN_CTRL) ||
                   ((sub >= `SBR_SP_SUB_EXT_FIRST) && (sub <= `SBR_SP_SUB_EXT_LAST));
  endfunction

  // pointer register, written directly
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ptr_r <= `SBR_RST_WORD;
    end else if (i_ptr_wr) begin
      ptr_r <= i_wdata;
    end
  end

  // window write lands on the selected register; holes ignore it
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < `SBR_SP_DEPTH; k++) begin
        bank_r[k] <= `SBR_RST_WORD;
      end
    end else if (i_win_wr && sp_sub_valid(ptr_r)) begin
      bank_r[ptr_r[4:0]] <= i_wdata;
    end
  end

  // read path, zero for a hole
  assign o_win_hit = sp_sub_valid(ptr_r);
  assign o_win_rdata = o_win_hit ? bank_r[ptr_r[4:0]] : `SBR_RST_WORD;
  assign o_ptr = ptr_r;

endmodule

/* verification/sbr_top_checker.sv */
/*
  Checker for sbr_top: read answers, write notifies and the priority register.
  Assumes one clock and an asynchronous active-high reset.
*/
module sbr_top_checker (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  input wire logic o_rvalid,
  input wire logic [2:0] o_sp_wr,
  input wire logic [15:0] o_sp_wr_data,
  input wire logic o_dma_wr,
  input wire logic [15:0] o_dma_wr_sub,
  input wire logic [15:0] o_dma_wr_data,
  input wire logic [15:0] o_dma_prio_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // two writes in a row through one dma window
  sequence s_auto2;
    i_wr && i_addr == 16'h0056 ##1 i_wr && i_addr == 16'h0056;
  endsequence
  sequence s_plain2;
    i_wr && i_addr == 16'h0057 ##1 i_wr && i_addr == 16'h0057;
  endsequence
  a_read_answered: assert property (i_rd |=> o_rvalid)
    else $error("read not answered next cycle");
  a_no_stray_answer: assert property (!i_rd |=> !o_rvalid)
    else $error("answer without a read");
  a_serial_notify_cause: assert property (o_sp_wr != 3'h0 |-> $past(i_wr) && o_sp_wr ==
    {$past(i_addr) == 16'h0035, $past(i_addr) == 16'h0049, $past(i_addr) == 16'h0039})
    else $error("serial notify without its window write");
  a_serial_notify_data: assert property (o_sp_wr != 3'h0 |-> o_sp_wr_data == $past(i_wdata))
    else $error("serial notify data wrong");
  a_dma_notify_cause: assert property (o_dma_wr |-> $past(i_wr) &&
    ($past(i_addr) == 16'h0056 || $past(i_addr) == 16'h0057))
    else $error("dma notify without a window write");
  a_dma_notify_data: assert property (o_dma_wr |-> o_dma_wr_data == $past(i_wdata))
    else $error("dma notify data wrong");
  a_prio_written: assert property (i_wr && i_addr == 16'h0054 |=>
    o_dma_prio_enable == $past(i_wdata)) else $error("priority register not written");
  a_prio_held: assert property (!(i_wr && i_addr == 16'h0054) |=>
    $stable(o_dma_prio_enable)) else $error("priority register changed");
  a_auto_step: assert property (s_auto2 |=> (o_dma_wr && $past(o_dma_wr)) |->
    o_dma_wr_sub == $past(o_dma_wr_sub) + 16'h0001) else $error("pointer did not step");
  a_plain_stays: assert property (s_plain2 |=> (o_dma_wr && $past(o_dma_wr)) |->
    o_dma_wr_sub == $past(o_dma_wr_sub)) else $error("plain window moved pointer");
endmodule

bind sbr_top sbr_top_checker sbr_top_checker_inst (.i_clk_sys, .i_reset, .i_addr, .i_rd,
  .i_wr, .i_wdata, .o_rvalid, .o_sp_wr, .o_sp_wr_data, .o_dma_wr, .o_dma_wr_sub,
  .o_dma_wr_data, .o_dma_prio_enable);

/* verification/sbr_cpu_model.sv */
/*
  Core data-memory bus model: issues reads and writes, back to back or spaced.
  Assumes the design samples requests at the rising edge.
*/
module sbr_cpu_model (
  input wire logic i_clk_sys,
  output logic [15:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    o_addr = 16'h0000;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 16'h0000;
  end
  // one request set at the falling edge, held through the taking edge
  task put(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
    @(negedge i_clk_sys);
    o_wr = w;
    o_rd = r;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk_sys);
  endtask
  // release: address and data show their inverse, never the last value
  task idle();
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask
endmodule

/* verification/test_subbank_register_access.sv */
/*
  Bench for sbr_top: each scenario drives the core bus model and judges.
  Assumes sbr_cpu_model and the bound checker.
*/
module test_subbank_register_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [15:0] addr, wdata, rdata, sp_sub, sp_data, dma_sub, dma_data, prio;
  logic rd, wr, rvalid, dma_wr;
  logic [2:0] sp_wr;
  int n_errors = 0;
  int n_compared = 0;
  // 200 MHz core clock
  always #2.5 i_clk_sys = ~i_clk_sys;
  sbr_cpu_model sbr_cpu_model_inst (.i_clk_sys(i_clk_sys), .o_addr(addr), .o_rd(rd),
    .o_wr(wr), .o_wdata(wdata));
  sbr_top sbr_top_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(addr), .i_rd(rd),
    .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .o_sp_wr(sp_wr),
    .o_sp_wr_sub(sp_sub), .o_sp_wr_data(sp_data), .o_dma_wr(dma_wr), .o_dma_wr_sub(dma_sub),
    .o_dma_wr_data(dma_data), .o_dma_prio_enable(prio));
  // compare one 16-bit result
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // single write, then let its notify show
  task wr1(input logic [15:0] a, input logic [15:0] d);
    sbr_cpu_model_inst.put(1'b1, 1'b0, a, d);
    sbr_cpu_model_inst.idle();
  endtask
  // single read; the answer stands in the cycle after the taking edge
  task rd1(input logic [15:0] a, output logic [15:0] v);
    sbr_cpu_model_inst.put(1'b0, 1'b1, a, 16'h0000);
    sbr_cpu_model_inst.idle();
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    v = rdata;
  endtask
  // priority, dma pointer and port 0 pointer read zero after reset, unmapped place too
  task sc_reset();
    logic [15:0] v;
    logic [15:0] al[4] = '{16'h0054, 16'h0055, 16'h0038, 16'h0036};
    foreach (al[i]) begin
      rd1(al[i], v);
      chk("reset read", 16'h0000, v);
    end
  endtask
  // each port: pointer picks the register behind its window, holes read zero
  task sc_serial();
    logic [15:0] v, d, e;
    logic [15:0] pa[3] = '{16'h0038, 16'h0048, 16'h0034};
    logic [15:0] sl[7] = '{16'h0000, 16'h000E, 16'h0010, 16'h001B, 16'h000F, 16'h001C,
                          16'h0100};
    for (int p = 0; p < 3; p++) begin
      foreach (sl[s]) begin
        d = {4'hA, p[3:0], sl[s][7:0]};
        // only 00h-0Eh and 010h-01Bh hold a register; everything else is a hole
        e = ((sl[s] <= 16'h000E) || ((sl[s] >= 16'h0010) && (sl[s] <= 16'h001B))) ? d :
            16'h0000;
        wr1(pa[p], sl[s]);
        wr1(pa[p] + 16'h0001, d);
        chk("sp_wr", (e == 16'h0000) ? 16'h0000 : 16'h0001 << p, {13'h0000, sp_wr});
        if (e != 16'h0000) chk("sp_sub", sl[s], sp_sub);
        if (e != 16'h0000) chk("sp data", d, sp_data);
        rd1(pa[p], v);
        chk("sp pointer", sl[s], v);
        rd1(pa[p] + 16'h0001, v);
        chk("sp window", e, v);
      end
    end
  endtask
  // direct priority register, untouched by window traffic
  task sc_prio();
    logic [15:0] v;
    wr1(16'h0054, 16'h5A5A);
    wr1(16'h0057, 16'h1234);
    chk("prio port", 16'h5A5A, prio);
    rd1(16'h0054, v);
    chk("prio read", 16'h5A5A, v);
  endtask
  // auto-increment burst across channel, page and index registers
  task sc_dma();
    logic [15:0] v;
    wr1(16'h0055, 16'h001D);
    for (int i = 0; i < 5; i++) sbr_cpu_model_inst.put(1'b1, 1'b0, 16'h0056, 16'hB000 + 16'(i));
    sbr_cpu_model_inst.idle();
    chk("dma sub", 16'h0021, dma_sub);
    chk("dma data", 16'hB004, dma_data);
    rd1(16'h0055, v);
    chk("dma pointer", 16'h0022, v);
    wr1(16'h0055, 16'h001D);
    rd1(16'h0057, v);
    chk("plain read", 16'hB000, v);
    rd1(16'h0055, v);
    chk("pointer kept", 16'h001D, v);
    for (int i = 0; i < 5; i++) begin
      rd1(16'h0056, v);
      chk("auto read", 16'hB000 + 16'(i), v);
    end
    wr1(16'h0055, 16'h0028);
    wr1(16'h0057, 16'hFFFF);
    chk("hole notify", 16'h0000, {15'h0000, dma_wr});
    rd1(16'h0057, v);
    chk("hole read", 16'h0000, v);
    wr1(16'h0055, 16'h003E);
    sbr_cpu_model_inst.put(1'b1, 1'b0, 16'h0057, 16'hC3E0);
    sbr_cpu_model_inst.put(1'b1, 1'b0, 16'h0057, 16'hC3E1);
    sbr_cpu_model_inst.idle();
    chk("enable sub", 16'h003E, dma_sub);
    chk("enable data", 16'hC3E1, dma_data);
    rd1(16'h0057, v);
    chk("enable read", 16'hC3E1, v);
  endtask
  // counts, verdict and end of run
  task wrap_up();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // reset for 16 cycles, then the scenarios
  initial begin
    repeat (16) @(negedge i_clk_sys);
    i_reset = 1'b0;
    sc_reset();
    sc_serial();
    sc_prio();
    sc_dma();
    wrap_up();
  end
endmodule
